// [rtl/bsl_fifo.sv]
// Synchronous valid/ready FIFO in front of the loader
`default_nettype none
module bsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Fill side
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // Drain side
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign rd_valid = wp_q != rp_q;
  assign wr_ready = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
  assign rd_data = mem[rp_q[AW-1:0]];
  assign push = clk_en && wr_valid && wr_ready;
  assign pop = clk_en && rd_valid && rd_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // bsl_fifo
`default_nettype wire

// [rtl/bsl_loader.sv]
// Boot init sequence and boot stream loader top
`default_nettype none
module bsl_loader #(
  parameter int DEPTH = bsl_pkg::BSL_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Boot port element stream
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  output logic in_ready,
  // Boot mode selector result
  input wire logic mode_valid,
  input wire logic allow_w8,
  input wire logic allow_w16,
  // Security password reads
  output logic sec_rd_req,
  output logic [2:0] sec_rd_idx,
  input wire logic sec_rd_valid,
  input wire logic [15:0] sec_rd_data,
  output logic sec_unlock,
  // Processor mode
  output logic obj_mode,
  // Memory writes
  output logic mem_wr_valid,
  output bsl_pkg::bsl_mem_wr_t mem_wr,
  input wire logic mem_wr_ready,
  // Result and exit
  output logic done,
  output bsl_pkg::bsl_result_t result,
  output logic cpu_restore,
  output logic jump_valid
);
  bsl_pkg::bsl_state_t state_q;
  bsl_pkg::bsl_mem_wr_t mem_q;
  logic [15:0] fifo_d, w_data, ent_hi_q, dst_hi_q, left_q, key8;
  logic [31:0] entry_q, addr_q;
  logic [7:0] first_q;
  logic [3:0] cnt_q;
  logic fifo_v, fifo_rdy, w_valid, w_ready, word_take, key_take, key_phase, word_phase, asm_in_ready;
  logic byte_mode_q, abort_q, mem_valid_q, obj_q, sec_ok_q, sec_unlock_q, sec_pend_q;

  bsl_fifo #(
    .WIDTH(bsl_pkg::BSL_ELEM_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .wr_valid(in_valid),
    .wr_data(in_data),
    .wr_ready(in_ready),
    .rd_valid(fifo_v),
    .rd_data(fifo_d),
    .rd_ready(fifo_rdy)
  );

  // Key detection reads raw elements; everything later reads assembled words
  assign key_phase = (state_q == bsl_pkg::S_KEY1) || (state_q == bsl_pkg::S_KEY2);
  assign word_phase = (state_q >= bsl_pkg::S_HDR) && (state_q <= bsl_pkg::S_DATA);
  assign key_take = clk_en && key_phase && fifo_v;
  assign key8 = {fifo_d[7:0], first_q};

  assign fifo_rdy = key_phase ? 1'b1 : (word_phase && asm_in_ready);

  bsl_word_asm u_asm (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .byte_mode(byte_mode_q),
    .in_valid(fifo_v && word_phase),
    .in_data(fifo_d),
    .in_ready(asm_in_ready),
    .out_valid(w_valid),
    .out_data(w_data),
    .out_ready(w_ready)
  );

  // One word in flight to memory; a stalled memory backs up into the FIFO
  always_comb begin
    case (state_q)
      bsl_pkg::S_HDR, bsl_pkg::S_ENT_HI, bsl_pkg::S_ENT_LO, bsl_pkg::S_SIZE,
      bsl_pkg::S_DST_HI, bsl_pkg::S_DST_LO: w_ready = 1'b1;
      bsl_pkg::S_DATA: w_ready = !mem_valid_q;
      default: w_ready = 1'b0;
    endcase
  end
  assign word_take = clk_en && w_valid && w_ready;

  // Sequence control
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= bsl_pkg::S_OBJ;
      cnt_q <= 4'h0;
      byte_mode_q <= 1'b0;
      first_q <= 8'h00;
      abort_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        bsl_pkg::S_OBJ: begin
          state_q <= bsl_pkg::S_SEC;
          cnt_q <= 4'h0;
        end
        bsl_pkg::S_SEC: begin
          if (sec_rd_valid && sec_pend_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == bsl_pkg::BSL_PW_WORDS - 4'h1) begin
              state_q <= bsl_pkg::S_MODE;
            end
          end
        end
        bsl_pkg::S_MODE: begin
          if (mode_valid) begin
            state_q <= bsl_pkg::S_KEY1;
          end
        end
        bsl_pkg::S_KEY1: begin
          if (fifo_v) begin
            if (fifo_d == bsl_pkg::BSL_KEY_W16) begin
              byte_mode_q <= 1'b0;
              abort_q <= !allow_w16;
              state_q <= allow_w16 ? bsl_pkg::S_HDR : bsl_pkg::S_DONE;
              cnt_q <= 4'h0;
            end else begin
              first_q <= fifo_d[7:0];
              state_q <= bsl_pkg::S_KEY2;
            end
          end
        end
        bsl_pkg::S_KEY2: begin
          if (fifo_v) begin
            cnt_q <= 4'h0;
            if (key8 == bsl_pkg::BSL_KEY_W8 && allow_w8) begin
              byte_mode_q <= 1'b1;
              state_q <= bsl_pkg::S_HDR;
            end else begin
              abort_q <= 1'b1;
              state_q <= bsl_pkg::S_DONE;
            end
          end
        end
        bsl_pkg::S_HDR: begin
          if (word_take) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == bsl_pkg::BSL_HDR_WORDS - 4'h1) begin
              state_q <= bsl_pkg::S_ENT_HI;
            end
          end
        end
        bsl_pkg::S_ENT_HI: begin
          if (word_take) begin
            state_q <= bsl_pkg::S_ENT_LO;
          end
        end
        bsl_pkg::S_ENT_LO: begin
          if (word_take) begin
            state_q <= bsl_pkg::S_SIZE;
          end
        end
        bsl_pkg::S_SIZE: begin
          if (word_take) begin
            state_q <= (w_data == 16'h0000) ? bsl_pkg::S_DONE : bsl_pkg::S_DST_HI;
          end
        end
        bsl_pkg::S_DST_HI: begin
          if (word_take) begin
            state_q <= bsl_pkg::S_DST_LO;
          end
        end
        bsl_pkg::S_DST_LO: begin
          if (word_take) begin
            state_q <= bsl_pkg::S_DATA;
          end
        end
        bsl_pkg::S_DATA: begin
          if (word_take && left_q == 16'h0001) begin
            state_q <= bsl_pkg::S_SIZE;
          end
        end
        bsl_pkg::S_DONE: begin
          if (!mem_valid_q) begin
            state_q <= bsl_pkg::S_EXIT;
          end
        end
        bsl_pkg::S_EXIT: state_q <= bsl_pkg::S_RUN;
        bsl_pkg::S_RUN: state_q <= bsl_pkg::S_RUN;
        default: state_q <= bsl_pkg::S_OBJ;
      endcase
    end
  end

  // Entry address and block fields
  always_ff @(posedge mclk) begin
    if (srst) begin
      ent_hi_q <= 16'h0000;
      entry_q <= bsl_pkg::BSL_ENTRY_RST;
      dst_hi_q <= 16'h0000;
      addr_q <= 32'h0000_0000;
      left_q <= 16'h0000;
    end else if (clk_en) begin
      if ((key_take && state_q == bsl_pkg::S_KEY1 && fifo_d == bsl_pkg::BSL_KEY_W16 && !allow_w16)
          || (key_take && state_q == bsl_pkg::S_KEY2 && !(key8 == bsl_pkg::BSL_KEY_W8 && allow_w8))) begin
        entry_q <= bsl_pkg::BSL_FLASH_ENTRY;
      end
      if (word_take) begin
        case (state_q)
          bsl_pkg::S_ENT_HI: ent_hi_q <= w_data;
          bsl_pkg::S_ENT_LO: entry_q <= {ent_hi_q, w_data};
          bsl_pkg::S_SIZE: left_q <= w_data;
          bsl_pkg::S_DST_HI: dst_hi_q <= w_data;
          bsl_pkg::S_DST_LO: addr_q <= {dst_hi_q, w_data};
          bsl_pkg::S_DATA: begin
            addr_q <= addr_q + 32'h0000_0001;
            left_q <= left_q - 16'h0001;
          end
          default: ;
        endcase
      end
    end
  end

  // Memory write port
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_valid_q <= 1'b0;
      mem_q <= '0;
    end else if (clk_en) begin
      if (word_take && state_q == bsl_pkg::S_DATA) begin
        mem_valid_q <= 1'b1;
        mem_q <= '{addr: addr_q, data: w_data};
      end else if (mem_wr_ready) begin
        mem_valid_q <= 1'b0;
      end
    end
  end

  // Object mode and password dummy read
  always_ff @(posedge mclk) begin
    if (srst) begin
      obj_q <= 1'b0;
      sec_ok_q <= 1'b1;
      sec_unlock_q <= 1'b0;
      sec_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == bsl_pkg::S_OBJ) begin
        obj_q <= 1'b1;
      end
      if (sec_rd_req) begin
        sec_pend_q <= 1'b1;
      end else if (sec_rd_valid && state_q == bsl_pkg::S_SEC) begin
        sec_pend_q <= 1'b0;
        if (sec_rd_data != bsl_pkg::BSL_SEC_ERASED) begin
          sec_ok_q <= 1'b0;
        end
        if (cnt_q == bsl_pkg::BSL_PW_WORDS - 4'h1) begin
          sec_unlock_q <= sec_ok_q && (sec_rd_data == bsl_pkg::BSL_SEC_ERASED);
        end
      end
    end
  end

  assign sec_rd_req = (state_q == bsl_pkg::S_SEC) && !sec_pend_q;
  assign sec_rd_idx = cnt_q[2:0];
  assign sec_unlock = sec_unlock_q;
  assign obj_mode = obj_q;
  assign mem_wr_valid = mem_valid_q;
  assign mem_wr = mem_q;
  // Done waits for the last memory write to land
  assign done = (state_q == bsl_pkg::S_DONE) && !mem_valid_q;
  assign result = '{entry: entry_q, abort: abort_q};
  assign cpu_restore = state_q == bsl_pkg::S_EXIT;
  assign jump_valid = state_q == bsl_pkg::S_EXIT;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || !clk_en);

  a_key16_accept: assert property ((state_q == bsl_pkg::S_KEY1 && fifo_v
    && fifo_d == bsl_pkg::BSL_KEY_W16 && allow_w16) |=> state_q == bsl_pkg::S_HDR && !byte_mode_q)
    else $error("word key not accepted");
  a_key8_form: assert property ((state_q == bsl_pkg::S_KEY2 && fifo_v
    && key8 == bsl_pkg::BSL_KEY_W8 && allow_w8) |=> byte_mode_q && state_q == bsl_pkg::S_HDR)
    else $error("byte key not accepted");
  a_abort_flash: assert property (done && result.abort |-> result.entry == bsl_pkg::BSL_FLASH_ENTRY)
    else $error("abort without flash entry");
  a_bad_width: assert property ((state_q == bsl_pkg::S_KEY1 && fifo_v
    && fifo_d == bsl_pkg::BSL_KEY_W16 && !allow_w16) |=> ##[0:2] (done && result.abort))
    else $error("refused width not aborted");
  a_data_write: assert property ((state_q == bsl_pkg::S_DATA && word_take)
    |=> mem_wr_valid && mem_wr.addr == $past(addr_q) && mem_wr.data == $past(w_data)
    && addr_q == $past(addr_q) + 32'h0000_0001)
    else $error("data word misplaced");
  a_term_stop: assert property ((state_q == bsl_pkg::S_SIZE && word_take && w_data == 16'h0000)
    |=> state_q == bsl_pkg::S_DONE && !abort_q)
    else $error("terminator not honoured");
  a_mode_gate: assert property ((state_q == bsl_pkg::S_MODE && !mode_valid) |=> state_q == bsl_pkg::S_MODE)
    else $error("detection before mode valid");
  a_obj_first: assert property (state_q == bsl_pkg::S_OBJ |=> obj_mode && state_q == bsl_pkg::S_SEC)
    else $error("object mode not set first");
  a_sec_locked: assert property ((state_q == bsl_pkg::S_SEC && sec_pend_q && sec_rd_valid
    && sec_rd_data != bsl_pkg::BSL_SEC_ERASED) |=> !sec_ok_q && !sec_unlock)
    else $error("security unlocked by written password");
  a_exit_jump: assert property (done |=> cpu_restore && jump_valid ##1 !jump_valid)
    else $error("exit not taken after done");
  a_entry_capture: assert property ((state_q == bsl_pkg::S_ENT_LO && word_take)
    |=> entry_q == {$past(ent_hi_q), $past(w_data)})
    else $error("entry address misassembled");

  c_byte_load: cover property (done && !result.abort && byte_mode_q);
  c_word_load: cover property (done && !result.abort && !byte_mode_q);
  c_abort: cover property (done && result.abort);
  c_stall: cover property (mem_wr_valid && !mem_wr_ready ##1 !in_ready);
endmodule // bsl_loader
`default_nettype wire

// [rtl/bsl_pkg.sv]
// Constants, states and carriers shared by the boot stream loader files
`default_nettype none
package bsl_pkg;

  // Stream width keys
  localparam logic [15:0] BSL_KEY_W16 = 16'h10aa;
  localparam logic [15:0] BSL_KEY_W8 = 16'h08aa;

  // Erased security password word
  localparam logic [15:0] BSL_SEC_ERASED = 16'hffff;

  // Entry used when a load aborts, and entry value loaded at reset
  localparam logic [31:0] BSL_FLASH_ENTRY = 32'h003f_7ff6;
  localparam logic [31:0] BSL_ENTRY_RST = 32'h0000_0000;

  // Header words after the key, password words read at init
  localparam logic [3:0] BSL_HDR_WORDS = 4'h8;
  localparam logic [3:0] BSL_PW_WORDS = 4'h8;

  // Stream element width and buffer depth
  localparam int BSL_ELEM_W = 16;
  localparam int BSL_FIFO_DEPTH = 32;

  typedef enum logic [3:0] {
    S_OBJ    = 4'b0000,
    S_SEC    = 4'b0001,
    S_MODE   = 4'b0010,
    S_KEY1   = 4'b0011,
    S_KEY2   = 4'b0100,
    S_HDR    = 4'b0101,
    S_ENT_HI = 4'b0110,
    S_ENT_LO = 4'b0111,
    S_SIZE   = 4'b1000,
    S_DST_HI = 4'b1001,
    S_DST_LO = 4'b1010,
    S_DATA   = 4'b1011,
    S_DONE   = 4'b1100,
    S_EXIT   = 4'b1101,
    S_RUN    = 4'b1110
  } bsl_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } bsl_mem_wr_t;

  typedef struct packed {
    logic [31:0] entry;
    logic abort;
  } bsl_result_t;

endpackage
`default_nettype wire

// [rtl/bsl_word_asm.sv]
// Builds 16-bit words from the element stream, low byte first in byte mode
`default_nettype none
module bsl_word_asm (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Mode
  input wire logic byte_mode,
  // Elements in
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  output logic in_ready,
  // Words out
  output logic out_valid,
  output logic [15:0] out_data,
  input wire logic out_ready
);
  logic [7:0] lo_q;
  logic have_lo_q;
  logic out_valid_q;
  logic [15:0] out_q;
  logic take_in;
  logic take_out;

  assign in_ready = !out_valid_q || out_ready;
  assign take_in = clk_en && in_valid && in_ready;
  assign take_out = clk_en && out_valid_q && out_ready;
  assign out_valid = out_valid_q;
  assign out_data = out_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      lo_q <= 8'h00;
      have_lo_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_q <= 16'h0000;
    end else begin
      if (take_out) begin
        out_valid_q <= 1'b0;
      end
      if (take_in) begin
        if (!byte_mode) begin
          out_q <= in_data;
          out_valid_q <= 1'b1;
        end else if (!have_lo_q) begin
          lo_q <= in_data[7:0];
          have_lo_q <= 1'b1;
        end else begin
          out_q <= {in_data[7:0], lo_q};
          have_lo_q <= 1'b0;
          out_valid_q <= 1'b1;
        end
      end
    end
  end
endmodule // bsl_word_asm
`default_nettype wire

// [verif/bsl_host_model.sv]
// Behavioural host that feeds boot stream elements to the loader
`default_nettype none
module bsl_host_model (
  // Clock
  input wire logic mclk,
  // Element stream
  output logic in_valid,
  output logic [15:0] in_data,
  input wire logic in_ready,
  // Pacing
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] q [$];
  logic took;
  logic tog;

  initial begin
    in_valid = 1'b0;
    in_data = 16'h0000;
    tog = 1'b0;
  end

  task automatic push(input logic [15:0] e);
    q.push_back(e);
  endtask

  task automatic flush();
    q.delete();
  endtask

  // An offer stays up until taken; idle data toggles so stale values never match
  always @(posedge mclk) begin
    took = (in_valid === 1'b1) && (in_ready === 1'b1);
    #1;
    tog = ~tog;
    if (took && q.size() != 0) begin
      void'(q.pop_front());
    end
    if (in_valid && !took) begin
      in_valid = 1'b1;
    end else if (q.size() != 0 && !(slow && tog)) begin
      in_valid = 1'b1;
      in_data = q[0];
    end else begin
      in_valid = 1'b0;
      in_data = ~in_data;
    end
  end
endmodule // bsl_host_model
`default_nettype wire

// [verif/bsl_loader_tb_top.sv]
// Self-checking bench for the boot stream loader
`default_nettype none
module bsl_loader_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk, srst, clk_en, mode_valid, allow_w8, allow_w16, slow, mem_slow, bmode;
  logic in_valid, in_ready, sec_rd_req, sec_rd_valid, sec_unlock, obj_mode;
  logic mem_wr_valid, mem_wr_ready, done, cpu_restore, jump_valid, pend, req_s, done_d;
  logic [15:0] in_data, sec_rd_data;
  logic [2:0] sec_rd_idx, pend_idx, idx_s;
  logic [15:0] pw [8];
  bsl_pkg::bsl_mem_wr_t mem_wr;
  bsl_pkg::bsl_result_t result, got_res;
  logic [31:0] exp_a [$];
  logic [31:0] got_a [$];
  logic [15:0] exp_d [$];
  logic [15:0] got_d [$];
  int mismatches, check_count, done_n, cyc;

  bsl_loader #(.DEPTH(32)) i_bsl_loader (
    .mclk(mclk), .srst(srst), .clk_en(clk_en),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .mode_valid(mode_valid), .allow_w8(allow_w8), .allow_w16(allow_w16),
    .sec_rd_req(sec_rd_req), .sec_rd_idx(sec_rd_idx), .sec_rd_valid(sec_rd_valid),
    .sec_rd_data(sec_rd_data), .sec_unlock(sec_unlock), .obj_mode(obj_mode),
    .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
    .done(done), .result(result), .cpu_restore(cpu_restore), .jump_valid(jump_valid)
  );

  bsl_host_model i_bsl_host_model (
    .mclk(mclk), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .slow(slow)
  );

  always #5 mclk = ~mclk;

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watches results, exit pulses and memory writes at each edge
  always @(posedge mclk) begin
    if (done_d) chk(cpu_restore === 1'b1 && jump_valid === 1'b1 && done === 1'b0, "exit pulses");
    done_d = (done === 1'b1);
    if (done_d) begin
      done_n++;
      got_res = result;
    end
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      got_a.push_back(mem_wr.addr);
      got_d.push_back(mem_wr.data);
    end
  end

  // Password store answers two cycles after each request; memory stalls two of three cycles
  always @(posedge mclk) begin
    req_s = sec_rd_req;
    idx_s = sec_rd_idx;
    #1;
    cyc++;
    mem_wr_ready = !mem_slow || (cyc % 3 == 0);
    sec_rd_valid = pend;
    sec_rd_data = pend ? pw[pend_idx] : ~sec_rd_data;
    pend = (req_s === 1'b1);
    pend_idx = idx_s;
  end

  task automatic put(input logic [15:0] w);
    if (bmode) begin
      i_bsl_host_model.push({8'h5a, w[7:0]});
      i_bsl_host_model.push({8'h5a, w[15:8]});
    end else begin
      i_bsl_host_model.push(w);
    end
  endtask

  task automatic put_block(input logic [31:0] a, input int n, input logic [15:0] d0);
    put(16'(n));
    put(a[31:16]);
    put(a[15:0]);
    for (int i = 0; i < n; i++) begin
      put(d0 + 16'(i));
      exp_a.push_back(a + 32'(i));
      exp_d.push_back(d0 + 16'(i));
    end
  endtask

  task automatic start(input logic bm, input logic w8, input logic w16, input logic [15:0] pw7);
    @(posedge mclk);
    #1;
    srst = 1'b1;
    mode_valid = 1'b0;
    bmode = bm;
    allow_w8 = w8;
    allow_w16 = w16;
    for (int i = 0; i < 8; i++) pw[i] = 16'hffff;
    pw[7] = pw7;
    i_bsl_host_model.flush();
    exp_a.delete();
    exp_d.delete();
    got_a.delete();
    got_d.delete();
    done_n = 0;
    repeat (4) @(posedge mclk);
    #1;
    srst = 1'b0;
    chk(obj_mode === 1'b0, "object mode during reset");
    @(posedge mclk);
    #1;
    chk(obj_mode === 1'b1, "object mode after reset");
  endtask

  task automatic put_head(input logic [15:0] key);
    put(key);
    for (int i = 0; i < 8; i++) put(16'hfff0 + 16'(i));
    put(16'h003f);
    put(16'h8000);
  endtask

  task automatic finish_load(input logic [31:0] ent, input logic ab, input logic unl);
    for (int i = 0; i < 3000 && done_n == 0; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    #1;
    chk(done_n == 1, "done pulse count");
    chk(got_res.entry === ent && got_res.abort === ab, "entry or abort");
    chk(sec_unlock === unl, "security unlock");
    chk(got_a.size() == exp_a.size(), "write count");
    foreach (exp_a[i]) if (i < got_a.size()) chk(got_a[i] === exp_a[i] && got_d[i] === exp_d[i], "write");
  endtask

  task automatic t_word_stream();
    start(1'b0, 1'b1, 1'b1, 16'hffff);
    mem_slow = 1'b1;
    slow = 1'b0;
    mode_valid = 1'b1;
    put_head(16'h10aa);
    put_block(32'h003f9010, 5, 16'h0001);
    put_block(32'h003f8000, 2, 16'h7700);
    put(16'h0000);
    finish_load(32'h003f8000, 1'b0, 1'b1);
  endtask

  // Whole byte stream is queued before the mode is known so the buffer fills
  task automatic t_byte_stream();
    start(1'b1, 1'b1, 1'b1, 16'h0000);
    mem_slow = 1'b0;
    slow = 1'b1;
    put_head(16'h08aa);
    put_block(32'h003f9010, 10, 16'h0100);
    put_block(32'h003f8000, 1, 16'h7625);
    put(16'h0000);
    repeat (90) @(posedge mclk);
    #1;
    chk(in_ready === 1'b0 && got_a.size() == 0 && done_n == 0, "load before mode known");
    mode_valid = 1'b1;
    finish_load(32'h003f8000, 1'b0, 1'b0);
  endtask

  // Refused word key, refused byte key, unknown key
  task automatic t_abort();
    for (int k = 0; k < 3; k++) begin
      start(k != 0, k != 1, k == 2, 16'hffff);
      mem_slow = 1'b0;
      slow = 1'b0;
      mode_valid = 1'b1;
      put(k == 2 ? 16'h1234 : (k == 0 ? 16'h10aa : 16'h08aa));
      put(16'h0000);
      finish_load(32'h003f7ff6, 1'b1, 1'b1);
    end
  endtask

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    clk_en = 1'b1;
    mode_valid = 1'b0;
    allow_w8 = 1'b0;
    allow_w16 = 1'b0;
    slow = 1'b0;
    mem_slow = 1'b0;
    bmode = 1'b0;
    sec_rd_valid = 1'b0;
    sec_rd_data = 16'h0000;
    mem_wr_ready = 1'b1;
    pend = 1'b0;
    done_d = 1'b0;
    t_word_stream();
    t_byte_stream();
    t_abort();
    conclude();
  end

  initial begin
    #200000;
    mismatches++;
    $display("ERROR at %0t: run did not finish in time", $time);
    conclude();
  end
endmodule // bsl_loader_tb_top
`default_nettype wire
